// ==== hdl/cti_channel.sv ====
// Functional notes
// - lead-in count zero sends none, else that many
// - trailing count zero sends none, else that many
// - no bit insertion while trailer is sent
// - two-bit select picks timer clock source
// - mode clear: timer reloads, interrupts each expiry
// - mode set: timer expires once then stops
// - period is count plus one source ticks
// - version word: firmware, bus revision, device
// - frame start flag on valid frame begin
// - receive trigger flag when fill exceeds level
// - frame end flag on length entry write
// - overflow flag beyond 512 length entries
// - data overflow flag beyond 8K receive depth
// - frame lost flag and status word mark
// - timer expiry flag on every expiry
// - dma halts on stop until go command
// - dma frame end and host flags
// - transmit trigger flag below level or start
// - all-sent flag on active to idle
// - underrun flag when idle before full count
// - change flags for modem input levels
// - masked events set no status bit, raise no interrupt
// - flow abort flag on clear-to-send change
`timescale 1ns/10ps
module cti_channel #(
  parameter logic [7:0]  CHAN_BASE = 8'h00,
  parameter logic [7:0]  FW_REV    = 8'h01,  // arbitrary value
  parameter logic [7:0]  BUS_REV   = 8'h01,  // arbitrary value
  parameter logic [15:0] BUS_DEV   = 16'h0A5A // arbitrary value
) (
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  input  wire logic [31:0] reg_wdata_in,
  output logic      [31:0] reg_rdata_out,
  input  wire logic [31:0] interrupt_mask_in,
  output logic             irq_out,
  input  wire logic        osc_tick_in,
  input  wire logic        tx_clk_tick_in,
  input  wire logic        rx_clk_tick_in,
  input  wire logic        tx_frame_req_in,
  input  wire logic        tx_byte_taken_in,
  input  wire logic        tx_frame_done_in,
  output logic             tx_pattern_valid_out,
  output logic      [7:0]  tx_pattern_out,
  output logic             tx_stuff_enable_out,
  output logic             tx_active_out,
  input  wire logic        transmit_frame_cmd_in,
  input  wire logic [13:0] tx_fifo_count_in,
  input  wire logic [13:0] tx_fill_threshold_in,
  input  wire logic [15:0] tx_bytes_pushed_in,
  input  wire logic [15:0] tx_frame_length_in,
  input  wire logic        rx_frame_start_in,
  input  wire logic [13:0] rx_fifo_count_in,
  input  wire logic [13:0] rx_fill_threshold_in,
  input  wire logic        rx_byte_push_in,
  input  wire logic        rx_length_write_in,
  input  wire logic        rx_status_append_in,
  input  wire logic [9:0]  rx_length_entries_in,
  input  wire logic        rx_msg_push_in,
  output logic             frame_lost_mark_out,
  input  wire logic        tx_dma_stop_in,
  input  wire logic        rx_dma_stop_in,
  input  wire logic        tx_go_in,
  input  wire logic        rx_go_in,
  input  wire logic        tx_dma_fe_in,
  input  wire logic        rx_dma_fe_in,
  input  wire logic        tx_dma_hi_in,
  input  wire logic        rx_dma_hi_in,
  output logic             tx_dma_halted_out,
  output logic             rx_dma_halted_out,
  input  wire logic        cts_in,
  input  wire logic        dsr_in,
  input  wire logic        cd_in,
  input  wire logic        cts_flow_ctl_in
);

  // ***************************************************************
  // address decode
  // ***************************************************************
  cti_pkg::cti_state_t s_q;
  cti_pkg::cti_state_t s_d;
  logic [31:0]         ev;
  logic                tmr_exp;
  logic                tick;
  logic                abort;
  logic                went_idle;
  logic                sel_ltc;
  logic                sel_tcr;
  logic                sel_version_status;
  logic                sel_isr;
  logic                tx_below;
  logic                rx_above;
  logic [2:0]          modem_now;
  logic [2:0]          modem_chg;

  // channel two sits at a higher window, so base is added before compare
  assign sel_ltc  = reg_addr_in == 8'(CHAN_BASE + cti_pkg::CTI_OFS_LTC);
  assign sel_tcr  = reg_addr_in == 8'(CHAN_BASE + cti_pkg::CTI_OFS_TCR);
  assign sel_version_status = reg_addr_in == 8'(CHAN_BASE + cti_pkg::CTI_OFS_VERSION_STATUS);
  assign sel_isr  = reg_addr_in == 8'(CHAN_BASE + cti_pkg::CTI_OFS_ISR);

  // level comparisons feeding edge-based trigger flags
  assign tx_below  = tx_fifo_count_in < tx_fill_threshold_in;
  assign rx_above  = rx_fifo_count_in > rx_fill_threshold_in;
  assign modem_now = {cd_in, dsr_in, cts_in};
  // first sample after reset only primes the history, no spurious change
  assign modem_chg = s_q.primed ? (modem_now ^ s_q.modem) : 3'h0;

  // ***************************************************************
  // next-state logic
  // ***************************************************************
  always_comb
  begin
    s_d       = s_q;
    ev        = 32'h0000_0000;
    tmr_exp   = 1'b0;
    went_idle = 1'b0;
    abort     = 1'b0;

    // register writes; read-only words ignore writes
    if (reg_wr_in && sel_ltc)
    begin
      s_d.ltc = reg_wdata_in;
    end

    // timer source select
    unique case (s_q.timer_config[cti_pkg::CTI_TIMER_CLOCK_SELECT_LSB +: 2])
      cti_pkg::CTI_TIMER_CLOCK_SELECT_OSC: tick = osc_tick_in;
      cti_pkg::CTI_TIMER_CLOCK_SELECT_TXC: tick = tx_clk_tick_in;
      cti_pkg::CTI_TIMER_CLOCK_SELECT_RXC: tick = rx_clk_tick_in;
      cti_pkg::CTI_TIMER_CLOCK_SELECT_BUS: tick = 1'b1;  // we already run on the bus clock
    endcase

    // writing the timer word restarts it; count n gives n+1 ticks
    if (reg_wr_in && sel_tcr)
    begin
      s_d.timer_config     = reg_wdata_in;
      s_d.tmr_cnt = reg_wdata_in[cti_pkg::CTI_TIMER_EXPIRATION_COUNT_MSB:cti_pkg::CTI_TIMER_EXPIRATION_COUNT_LSB];
      s_d.tmr_run = 1'b1;
    end
    else if (s_q.tmr_run && tick)
    begin
      if (s_q.tmr_cnt == 29'h0000_0000)
      begin
        tmr_exp = 1'b1;
        if (s_q.timer_config[cti_pkg::CTI_TONE_BIT])
        begin
          s_d.tmr_run = 1'b0;
        end
        else
        begin
          s_d.tmr_cnt = s_q.timer_config[cti_pkg::CTI_TIMER_EXPIRATION_COUNT_MSB:cti_pkg::CTI_TIMER_EXPIRATION_COUNT_LSB];
        end
      end
      else
      begin
        s_d.tmr_cnt = s_q.tmr_cnt - 29'h0000_0001;
      end
    end

    // transmit lead-in / frame / trailer sequencer
    unique case (s_q.tx_st)
      cti_pkg::CTI_TX_IDLE:
      begin
        if (tx_frame_req_in)
        begin
          if (s_d.ltc[cti_pkg::CTI_LEAD_IN_COUNT_LSB +: 8] != 8'h00)
          begin
            s_d.tx_st = cti_pkg::CTI_TX_LEAD;
            s_d.rep   = s_d.ltc[cti_pkg::CTI_LEAD_IN_COUNT_LSB +: 8];
          end
          else
          begin
            s_d.tx_st = cti_pkg::CTI_TX_FRAME;
          end
        end
      end
      cti_pkg::CTI_TX_LEAD:
      begin
        if (tx_byte_taken_in)
        begin
          s_d.rep = s_q.rep - 8'h01;
          if (s_q.rep == 8'h01)
          begin
            s_d.tx_st = cti_pkg::CTI_TX_FRAME;
          end
        end
      end
      cti_pkg::CTI_TX_FRAME:
      begin
        if (tx_frame_done_in)
        begin
          if (s_d.ltc[cti_pkg::CTI_TRAIL_COUNT_LSB +: 8] != 8'h00)
          begin
            s_d.tx_st = cti_pkg::CTI_TX_TRAIL;
            s_d.rep   = s_d.ltc[cti_pkg::CTI_TRAIL_COUNT_LSB +: 8];
          end
          else
          begin
            s_d.tx_st = cti_pkg::CTI_TX_IDLE;
          end
        end
      end
      cti_pkg::CTI_TX_TRAIL:
      begin
        if (tx_byte_taken_in)
        begin
          s_d.rep = s_q.rep - 8'h01;
          if (s_q.rep == 8'h01)
          begin
            s_d.tx_st = cti_pkg::CTI_TX_IDLE;
          end
        end
      end
    endcase

    // a clear-to-send change under flow control aborts the transmission
    abort = cts_flow_ctl_in && modem_chg[0] && s_q.tx_active;
    if (abort)
    begin
      s_d.tx_st = cti_pkg::CTI_TX_IDLE;
    end
    went_idle = s_q.tx_active && (s_d.tx_st == cti_pkg::CTI_TX_IDLE);

    // serializer-facing outputs follow the next state
    s_d.pat_valid = (s_d.tx_st == cti_pkg::CTI_TX_LEAD) || (s_d.tx_st == cti_pkg::CTI_TX_TRAIL);
    s_d.pat       = (s_d.tx_st == cti_pkg::CTI_TX_TRAIL) ? s_d.ltc[cti_pkg::CTI_TRAIL_PATTERN_LSB +: 8]
                                                         : s_d.ltc[cti_pkg::CTI_PRE_LSB +: 8];
    s_d.stuff_en  = s_d.tx_st != cti_pkg::CTI_TX_TRAIL;
    s_d.tx_active = s_d.tx_st != cti_pkg::CTI_TX_IDLE;

    // receive events
    ev[cti_pkg::CTI_B_RFS] = rx_frame_start_in;
    ev[cti_pkg::CTI_B_RFT] = rx_above && !s_q.rx_above;
    ev[cti_pkg::CTI_B_RFE] = rx_length_write_in || rx_status_append_in;
    ev[cti_pkg::CTI_B_RFO] = rx_length_write_in
                             && (rx_length_entries_in >= cti_pkg::CTI_LEN_ENTRIES);
    ev[cti_pkg::CTI_B_RDO] = rx_byte_push_in
                             && (rx_fifo_count_in >= cti_pkg::CTI_RX_DEPTH);
    ev[cti_pkg::CTI_B_RFL] = rx_frame_start_in && s_q.status[cti_pkg::CTI_B_RDO];
    s_d.rx_above = rx_above;

    // the status-word mark rides on the next pushed message; new loss wins
    if (rx_msg_push_in)
    begin
      s_d.lost_mark = 1'b0;
    end
    if (ev[cti_pkg::CTI_B_RFL])
    begin
      s_d.lost_mark = 1'b1;
    end

    // timer and dma events
    ev[cti_pkg::CTI_B_TIN]  = tmr_exp;
    ev[cti_pkg::CTI_B_DTST] = tx_dma_stop_in;
    ev[cti_pkg::CTI_B_DRST] = rx_dma_stop_in;
    ev[cti_pkg::CTI_B_DTFE] = tx_dma_fe_in;
    ev[cti_pkg::CTI_B_DRFE] = rx_dma_fe_in;
    ev[cti_pkg::CTI_B_DTHI] = tx_dma_hi_in;
    ev[cti_pkg::CTI_B_DRHI] = rx_dma_hi_in;
    // halt holds until the go command; a stop in the same cycle wins
    s_d.txh = (s_q.txh && !tx_go_in) || tx_dma_stop_in;
    s_d.rxh = (s_q.rxh && !rx_go_in) || rx_dma_stop_in;

    // transmit events
    ev[cti_pkg::CTI_B_TFT]  = (tx_below && !s_q.tx_below)
                              || (transmit_frame_cmd_in && tx_below);
    ev[cti_pkg::CTI_B_ALL_SENT_FLAG] = went_idle;
    ev[cti_pkg::CTI_B_TDU]  = went_idle && (tx_bytes_pushed_in < tx_frame_length_in);
    s_d.tx_below = tx_below;

    // modem line events
    ev[cti_pkg::CTI_B_CLEAR_TO_SEND_CHANGE_FLAG] = modem_chg[0];
    ev[cti_pkg::CTI_B_DATA_SET_READY_CHANGE_FLAG] = modem_chg[1];
    ev[cti_pkg::CTI_B_CDC]  = modem_chg[2];
    ev[cti_pkg::CTI_B_FLOW_ABORT_FLAG] = abort;
    s_d.modem  = modem_now;
    s_d.primed = 1'b1;

    // read clears what was returned; an event in the same cycle survives
    if (reg_rd_in && sel_isr)
    begin
      s_d.status = 32'h0000_0000;
    end
    s_d.status = s_d.status | (ev & ~interrupt_mask_in);
    s_d.irq    = |s_d.status;

    // read data is registered, valid the cycle after the strobe
    if (reg_rd_in)
    begin
      if (sel_ltc)
        s_d.rdata = s_q.ltc;
      else if (sel_tcr)
        s_d.rdata = s_q.timer_config;
      else if (sel_version_status)
        s_d.rdata = {BUS_DEV, BUS_REV, FW_REV};
      else if (sel_isr)
        s_d.rdata = s_q.status;
      else
        s_d.rdata = 32'h0000_0000;
    end
  end

  // ***************************************************************
  // state register
  // ***************************************************************
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      s_q          <= '0;
      s_q.ltc      <= cti_pkg::CTI_REG_RST;
      s_q.timer_config      <= cti_pkg::CTI_REG_RST;
      s_q.tx_below <= 1'b1;  // avoids a trigger flag right out of reset
      s_q.stuff_en <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // outputs straight from flops
  assign reg_rdata_out        = s_q.rdata;
  assign irq_out              = s_q.irq;
  assign tx_pattern_valid_out = s_q.pat_valid;
  assign tx_pattern_out       = s_q.pat;
  assign tx_stuff_enable_out  = s_q.stuff_en;
  assign tx_active_out        = s_q.tx_active;
  assign frame_lost_mark_out  = s_q.lost_mark;
  assign tx_dma_halted_out    = s_q.txh;
  assign rx_dma_halted_out    = s_q.rxh;

  // ***************************************************************
  // assertions
  // ***************************************************************
  property p_lead_none;
    @(posedge clk_in) disable iff (reset_in)
    (s_q.tx_st == cti_pkg::CTI_TX_IDLE && tx_frame_req_in
     && s_d.ltc[cti_pkg::CTI_LEAD_IN_COUNT_LSB +: 8] == 8'h00) |=> !tx_pattern_valid_out;
  endproperty
  a_lead_none: assert property (p_lead_none) else $error("lead-in sent with zero count");

  property p_lead_load;
    @(posedge clk_in) disable iff (reset_in)
    (s_q.tx_st == cti_pkg::CTI_TX_IDLE && tx_frame_req_in
     && s_d.ltc[cti_pkg::CTI_LEAD_IN_COUNT_LSB +: 8] != 8'h00)
    |=> (s_q.tx_st == cti_pkg::CTI_TX_LEAD && s_q.rep == $past(s_d.ltc[31:24]));
  endproperty
  a_lead_load: assert property (p_lead_load) else $error("lead-in count not loaded");

  property p_trail_none;
    @(posedge clk_in) disable iff (reset_in)
    (s_q.tx_st == cti_pkg::CTI_TX_FRAME && tx_frame_done_in && !abort
     && s_d.ltc[cti_pkg::CTI_TRAIL_COUNT_LSB +: 8] == 8'h00) |=> !tx_active_out;
  endproperty
  a_trail_none: assert property (p_trail_none) else $error("trailer with zero count");

  property p_trail_nostuff;
    @(posedge clk_in) disable iff (reset_in)
    (s_q.tx_st == cti_pkg::CTI_TX_TRAIL) |-> (!tx_stuff_enable_out && tx_pattern_valid_out);
  endproperty
  a_trail_nostuff: assert property (p_trail_nostuff) else $error("stuffing during trailer");

  property p_tmr_reload;
    @(posedge clk_in) disable iff (reset_in)
    (tmr_exp && !s_q.timer_config[cti_pkg::CTI_TONE_BIT] && !(reg_wr_in && sel_tcr))
    |=> (s_q.tmr_run && s_q.tmr_cnt == $past(s_q.timer_config[31:3]));
  endproperty
  a_tmr_reload: assert property (p_tmr_reload) else $error("timer did not reload");

  property p_tmr_once;
    @(posedge clk_in) disable iff (reset_in)
    (tmr_exp && s_q.timer_config[cti_pkg::CTI_TONE_BIT] && !(reg_wr_in && sel_tcr)) |=> !s_q.tmr_run;
  endproperty
  a_tmr_once: assert property (p_tmr_once) else $error("one-shot timer kept running");

  property p_tin;
    @(posedge clk_in) disable iff (reset_in)
    (tmr_exp && !interrupt_mask_in[cti_pkg::CTI_B_TIN]) |=> s_q.status[cti_pkg::CTI_B_TIN];
  endproperty
  a_tin: assert property (p_tin) else $error("timer expiry flag missing");

  property p_masked;
    @(posedge clk_in) disable iff (reset_in)
    (interrupt_mask_in[cti_pkg::CTI_B_RFS] && !s_q.status[cti_pkg::CTI_B_RFS])
    |=> !s_q.status[cti_pkg::CTI_B_RFS];
  endproperty
  a_masked: assert property (p_masked) else $error("masked event set status");

  property p_sticky;
    @(posedge clk_in) disable iff (reset_in)
    (s_q.status[cti_pkg::CTI_B_RFS] && !(reg_rd_in && sel_isr))
    |=> s_q.status[cti_pkg::CTI_B_RFS];
  endproperty
  a_sticky: assert property (p_sticky) else $error("status bit lost before read");

  property p_all_sent_flag;
    @(posedge clk_in) disable iff (reset_in)
    ($fell(tx_active_out) && !$past(interrupt_mask_in[cti_pkg::CTI_B_ALL_SENT_FLAG]))
    |-> s_q.status[cti_pkg::CTI_B_ALL_SENT_FLAG];
  endproperty
  a_all_sent_flag: assert property (p_all_sent_flag) else $error("all-sent flag missing");

  property p_halt;
    @(posedge clk_in) disable iff (reset_in)
    (tx_dma_halted_out && !tx_go_in) |=> tx_dma_halted_out;
  endproperty
  a_halt: assert property (p_halt) else $error("dma left halt without go");

  property p_version;
    @(posedge clk_in) disable iff (reset_in)
    (reg_rd_in && sel_version_status) |=> (reg_rdata_out == {BUS_DEV, BUS_REV, FW_REV});
  endproperty
  a_version: assert property (p_version) else $error("version word wrong");

  c_lead: cover property (@(posedge clk_in) disable iff (reset_in)
    s_q.tx_st == cti_pkg::CTI_TX_LEAD ##1 s_q.tx_st == cti_pkg::CTI_TX_FRAME);
  c_trail: cover property (@(posedge clk_in) disable iff (reset_in)
    s_q.tx_st == cti_pkg::CTI_TX_TRAIL ##1 s_q.tx_st == cti_pkg::CTI_TX_IDLE);
  c_timer: cover property (@(posedge clk_in) disable iff (reset_in) tmr_exp);

endmodule

// ==== inc/cti_pkg.sv ====
// ***************************************************************
// channel timer and event status constants
// ***************************************************************
package cti_pkg;

  // register byte offsets within one channel window
  localparam logic [7:0] CTI_OFS_LTC    = 8'h44;
  localparam logic [7:0] CTI_OFS_TCR    = 8'h48;
  localparam logic [7:0] CTI_OFS_VERSION_STATUS   = 8'h4C;
  localparam logic [7:0] CTI_OFS_ISR    = 8'h50;
  localparam logic [7:0] CTI_CH2_BASE   = 8'h80;
  localparam logic [31:0] CTI_REG_RST   = 32'h0000_0000;

  // lead_trail_config fields
  localparam int CTI_LEAD_IN_COUNT_LSB  = 24;
  localparam int CTI_PRE_LSB   = 16;
  localparam int CTI_TRAIL_COUNT_LSB = 8;
  localparam int CTI_TRAIL_PATTERN_LSB  = 0;

  // timer_config fields
  localparam int CTI_TIMER_CLOCK_SELECT_LSB  = 0;
  localparam int CTI_TONE_BIT  = 2;
  localparam int CTI_TIMER_EXPIRATION_COUNT_LSB  = 3;
  localparam int CTI_TIMER_EXPIRATION_COUNT_MSB  = 31;
  localparam logic [1:0] CTI_TIMER_CLOCK_SELECT_OSC = 2'h0;
  localparam logic [1:0] CTI_TIMER_CLOCK_SELECT_TXC = 2'h1;
  localparam logic [1:0] CTI_TIMER_CLOCK_SELECT_RXC = 2'h2;
  localparam logic [1:0] CTI_TIMER_CLOCK_SELECT_BUS = 2'h3;

  // interrupt_status bit positions
  localparam int CTI_B_RFS  = 0;
  localparam int CTI_B_RFT  = 1;
  localparam int CTI_B_RFE  = 2;
  localparam int CTI_B_RFO  = 3;
  localparam int CTI_B_RDO  = 4;
  localparam int CTI_B_RFL  = 5;
  localparam int CTI_B_TIN  = 8;
  localparam int CTI_B_DRHI = 10;
  localparam int CTI_B_DTHI = 11;
  localparam int CTI_B_DRFE = 12;
  localparam int CTI_B_DTFE = 13;
  localparam int CTI_B_DRST = 14;
  localparam int CTI_B_DTST = 15;
  localparam int CTI_B_TFT  = 16;
  localparam int CTI_B_ALL_SENT_FLAG = 17;
  localparam int CTI_B_TDU  = 18;
  localparam int CTI_B_CLEAR_TO_SEND_CHANGE_FLAG = 24;
  localparam int CTI_B_DATA_SET_READY_CHANGE_FLAG = 25;
  localparam int CTI_B_CDC  = 26;
  localparam int CTI_B_FLOW_ABORT_FLAG = 27;

  // receive limits
  localparam logic [13:0] CTI_RX_DEPTH   = 14'h2000;
  localparam logic [9:0]  CTI_LEN_ENTRIES = 10'h200;

  typedef enum logic [1:0] {
    CTI_TX_IDLE  = 2'b00,
    CTI_TX_LEAD  = 2'b01,
    CTI_TX_FRAME = 2'b10,
    CTI_TX_TRAIL = 2'b11
  } cti_tx_state_t;

  typedef struct packed {
    logic [31:0]   ltc;
    logic [31:0]   timer_config;
    logic [31:0]   status;
    logic [28:0]   tmr_cnt;
    logic          tmr_run;
    cti_tx_state_t tx_st;
    logic [7:0]    rep;
    logic [2:0]    modem;
    logic          primed;
    logic          tx_below;
    logic          rx_above;
    logic          txh;
    logic          rxh;
    logic          lost_mark;
    logic [31:0]   rdata;
    logic          pat_valid;
    logic [7:0]    pat;
    logic          stuff_en;
    logic          tx_active;
    logic          irq;
  } cti_state_t;

endpackage

// ==== tb/cti_host_model.sv ====
`timescale 1ns/10ps
// ****************************************
// host software side of the register path
// ****************************************
module cti_host_model (
  input  wire logic        clk_in,
  input  wire logic [31:0] rdata_in,
  output logic      [7:0]  addr_out,
  output logic             wr_out,
  output logic             rd_out,
  output logic      [31:0] wdata_out
);
  // bus idle from time zero so nothing is taken during reset
  initial
  begin
    addr_out = 8'h00;
    wr_out = 1'h0;
    rd_out = 1'h0;
    wdata_out = 32'h0000_0000;
  end

  // one-cycle write strobe; data inverted after so no stale word lingers
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    #1;
    addr_out = a;
    wdata_out = d;
    wr_out = 1'h1;
    @(posedge clk_in);
    #1;
    wr_out = 1'h0;
    wdata_out = ~d;
  endtask

  // one-cycle read strobe, word taken one cycle later
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    #1;
    addr_out = a;
    rd_out = 1'h1;
    @(posedge clk_in);
    #1;
    rd_out = 1'h0;
    d = rdata_in;
  endtask
endmodule

// ==== tb/channel_timer_irq_status_test.sv ====
`timescale 1ns/10ps
module channel_timer_irq_status_test;
  localparam logic [7:0]  FW  = 8'h3C; // arbitrary value
  localparam logic [7:0]  RV  = 8'h5A; // arbitrary value
  localparam logic [15:0] DV  = 16'hC3A5; // arbitrary value
  logic        clk_in, reset_in, tick, irq, pv, stuff, act, lost, txh, rxh, wr, rd;
  logic [19:0] ev;
  logic [31:0] mask, rdata, rv, wdata;
  logic [13:0] tx_thr, rx_cnt, rx_thr;
  logic [9:0]  ents;
  logic [7:0]  addr, pat;
  int          errors, num_checks, cyc, t1;

  cti_host_model i_cti_host_model (.clk_in(clk_in), .rdata_in(rdata), .addr_out(addr),
    .wr_out(wr), .rd_out(rd), .wdata_out(wdata));

  cti_channel #(.FW_REV(FW), .BUS_REV(RV), .BUS_DEV(DV)) i_cti_channel (
    .clk_in(clk_in), .reset_in(reset_in), .reg_addr_in(addr), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .interrupt_mask_in(mask), .irq_out(irq), .osc_tick_in(tick),
    .tx_clk_tick_in(tick), .rx_clk_tick_in(tick), .tx_frame_req_in(ev[17]),
    .tx_byte_taken_in(ev[18]), .tx_frame_done_in(ev[19]), .tx_pattern_valid_out(pv),
    .tx_pattern_out(pat), .tx_stuff_enable_out(stuff), .tx_active_out(act),
    .transmit_frame_cmd_in(ev[14]), .tx_fifo_count_in(14'h0000),
    .tx_fill_threshold_in(tx_thr), .tx_bytes_pushed_in(16'h0000),
    .tx_frame_length_in(16'h0004), .rx_frame_start_in(ev[0]), .rx_fifo_count_in(rx_cnt),
    .rx_fill_threshold_in(rx_thr), .rx_byte_push_in(ev[16]), .rx_length_write_in(ev[1]),
    .rx_status_append_in(ev[2]), .rx_length_entries_in(ents), .rx_msg_push_in(ev[15]),
    .frame_lost_mark_out(lost), .tx_dma_stop_in(ev[3]), .rx_dma_stop_in(ev[4]),
    .tx_go_in(ev[12]), .rx_go_in(ev[13]), .tx_dma_fe_in(ev[5]), .rx_dma_fe_in(ev[6]),
    .tx_dma_hi_in(ev[7]), .rx_dma_hi_in(ev[8]), .tx_dma_halted_out(txh),
    .rx_dma_halted_out(rxh), .cts_in(ev[9]), .dsr_in(ev[10]), .cd_in(ev[11]),
    .cts_flow_ctl_in(1'h0));

  // ****************************************
  // clock, source ticks and watchdog
  // ****************************************
  initial
  begin
    clk_in = 1'h0;
    forever #2 clk_in = ~clk_in;
  end
  // every other cycle, so slow sources show a doubled period
  always @(posedge clk_in)
  begin
    #1;
    tick = ~tick;
  end
  // cycle stamp, updated on the edge so reads after it are settled
  always @(posedge clk_in)
    cyc <= cyc + 1;
  initial
  begin
    #100000;
    errors++;
    close_out();
  end

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] b(input int k);
    return 32'h0000_0001 << k;
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic pulse(input int i);
    if (i >= 0)
    begin
      @(posedge clk_in);
      #1;
      ev[i] = 1'h1;
      @(posedge clk_in);
      #1;
      ev[i] = 1'h0;
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    i_cti_host_model.rd(a, rv);
    chk("register", e, rv);
  endtask
  // event, then irq level, status word, and cleared status after the read
  task automatic evt(input int i, input logic [31:0] e);
    pulse(i);
    repeat (3) @(posedge clk_in);
    #1;
    chk("irq", {31'h0, e != 0}, {31'h0, irq});
    rd_chk(cti_pkg::CTI_OFS_ISR, e);
    rd_chk(cti_pkg::CTI_OFS_ISR, 32'h0000_0000);
  endtask
  task automatic wait_irq(input logic l);
    for (int k = 0; k < 100 && irq !== l; k++)
      @(posedge clk_in) #1;
    chk("irq wait", {31'h0, l}, {31'h0, irq});
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs();
    rd_chk(cti_pkg::CTI_OFS_LTC, 32'h0000_0000);
    rd_chk(cti_pkg::CTI_OFS_TCR, 32'h0000_0000);
    i_cti_host_model.wr(cti_pkg::CTI_OFS_VERSION_STATUS, 32'hFFFF_FFFF);
    rd_chk(cti_pkg::CTI_OFS_VERSION_STATUS, {DV, RV, FW});
    rd_chk(8'h54, 32'h0000_0000);
  endtask
  task automatic t_mask();
    evt(0, 32'h0000_0000);
  endtask
  task automatic t_pattern();
    i_cti_host_model.wr(cti_pkg::CTI_OFS_LTC, 32'h02A5_013C);
    rd_chk(cti_pkg::CTI_OFS_LTC, 32'h02A5_013C);
    pulse(17);
    chk("lead", 32'h0000_07A5, {pv, stuff, act, pat});
    pulse(18);
    pulse(18);
    chk("lead end", 32'h0000_0000, {31'h0, pv});
    pulse(19);
    chk("trail", 32'h0000_023C, {pv, stuff, pat});
    pulse(18);
    chk("idle", 32'h0000_0000, {31'h0, act});
    evt(-1, b(cti_pkg::CTI_B_ALL_SENT_FLAG) | b(cti_pkg::CTI_B_TDU));
    i_cti_host_model.wr(cti_pkg::CTI_OFS_LTC, 32'h0000_0000);
    pulse(17);
    chk("no lead", 32'h0000_0001, {pv, act});
    pulse(19);
    chk("no trail", 32'h0000_0000, {pv, act});
    evt(-1, b(cti_pkg::CTI_B_ALL_SENT_FLAG) | b(cti_pkg::CTI_B_TDU));
  endtask
  task automatic t_timer();
    for (int s = 0; s < 4; s++)
    begin
      i_cti_host_model.wr(cti_pkg::CTI_OFS_TCR, {29'h9, 1'h0, 2'(s)});
      i_cti_host_model.rd(cti_pkg::CTI_OFS_ISR, rv);
      wait_irq(1'h0);
      wait_irq(1'h1);
      t1 = cyc;
      rd_chk(cti_pkg::CTI_OFS_ISR, b(cti_pkg::CTI_B_TIN));
      wait_irq(1'h0);
      wait_irq(1'h1);
      chk("period", (s == 3) ? 32'd10 : 32'd20, 32'(cyc - t1));
    end
    i_cti_host_model.wr(cti_pkg::CTI_OFS_TCR, {29'h9, 1'h1, 2'h3});
    i_cti_host_model.rd(cti_pkg::CTI_OFS_ISR, rv);
    wait_irq(1'h0);
    wait_irq(1'h1);
    i_cti_host_model.rd(cti_pkg::CTI_OFS_ISR, rv);
    repeat (40) @(posedge clk_in);
    evt(-1, 32'h0000_0000);
  endtask
  task automatic t_events();
    evt(0, b(cti_pkg::CTI_B_RFS));
    evt(1, b(cti_pkg::CTI_B_RFE));
    evt(2, b(cti_pkg::CTI_B_RFE));
    evt(3, b(cti_pkg::CTI_B_DTST));
    evt(4, b(cti_pkg::CTI_B_DRST));
    chk("halted", 32'h0000_0003, {txh, rxh});
    // go commands come from the host side as one-cycle pulses
    pulse(12);
    pulse(13);
    chk("resumed", 32'h0000_0000, {txh, rxh});
    evt(5, b(cti_pkg::CTI_B_DTFE));
    evt(6, b(cti_pkg::CTI_B_DRFE));
    evt(7, b(cti_pkg::CTI_B_DTHI));
    evt(8, b(cti_pkg::CTI_B_DRHI));
    evt(9, b(cti_pkg::CTI_B_CLEAR_TO_SEND_CHANGE_FLAG));
    evt(10, b(cti_pkg::CTI_B_DATA_SET_READY_CHANGE_FLAG));
    evt(11, b(cti_pkg::CTI_B_CDC));
    ents = 10'h200;
    evt(1, b(cti_pkg::CTI_B_RFE) | b(cti_pkg::CTI_B_RFO));
  endtask
  task automatic t_levels();
    rx_thr = 14'h0004;
    rx_cnt = 14'h0005;
    evt(-1, b(cti_pkg::CTI_B_RFT));
    rx_cnt = 14'h2000;
    pulse(16);
    evt(0, b(cti_pkg::CTI_B_RDO) | b(cti_pkg::CTI_B_RFS) | b(cti_pkg::CTI_B_RFL));
    chk("lost mark", 32'h0000_0001, {31'h0, lost});
    pulse(15);
    chk("lost used", 32'h0000_0000, {31'h0, lost});
    tx_thr = 14'h0004;
    evt(-1, b(cti_pkg::CTI_B_TFT));
    evt(14, b(cti_pkg::CTI_B_TFT));
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    {tick, cyc, errors, num_checks, ev, ents} = '0;
    {tx_thr, rx_cnt, rx_thr} = '0;
    mask = 32'hFFFF_FFFF;
    reset_in = 1'h1;
    repeat (6) @(posedge clk_in);
    #1;
    reset_in = 1'h0;
    t_regs();
    t_mask();
    mask = 32'h0000_0000;
    t_pattern();
    t_timer();
    t_events();
    t_levels();
    close_out();
  end
endmodule
